/* ftu_pkg.sv */
// constants, types and lookup tables for the fsk transmit, ring and keytone status block
//
// Behaviour
// - level code selects 0 to -14 dB attenuation
// - low tone two dB below high tone
// - ring field selects square, trapezoid or sine
// - trapezoid ring crest factor is 1.35
// - ring pin low when ring not selected
// - sync framing: eight bits, lsb first, 1200bps
// - async framing: start, eight bits, stop bit
// - missing byte sets the underflow status flag
// - sync underflow resends the held byte
// - setup bit 5 enables the tone decoder
// - disabled decoder clears its status and code
// - status change sets bit 5, masked interrupt
// - change on detect and loss; bit 4 level
// - digit reported as fixed 4-bit code table
// - status read clears 2,3,5; data write clears 6,7
// - irq low when any unmasked status bit set, released by a status read until the next event
package ftu_pkg;

  // -----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [3:0] IDX_DEVICE_ID = 4'h0;
  localparam logic [3:0] IDX_RESET = 4'h1;
  localparam logic [3:0] IDX_SETUP = 4'h3;
  localparam logic [3:0] IDX_MODE = 4'h4;
  localparam logic [3:0] IDX_TX_DATA = 4'h5;
  localparam logic [3:0] IDX_TX_TONES = 4'h6;
  localparam logic [3:0] IDX_LINK_CTRL = 4'h8;
  localparam logic [3:0] IDX_INT_MASK = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'ha;
  localparam logic [3:0] IDX_DIGIT = 4'hb;
  localparam logic [3:0] IDX_CODEC_CTRL = 4'hc;

  // device identity byte; the value is arbitrary
  localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] INT_MASK_WRITABLE = 8'hfc;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int SETUP_TX_EN_BIT = 6;
  localparam int SETUP_DEC_EN_BIT = 5;
  localparam int SETUP_RING_LSB = 2;
  localparam int SETUP_ASYNC_BIT = 1;
  localparam int MODE_LEVEL_LSB = 2;
  localparam int ST_RX_ABORT = 2;
  localparam int ST_TX_ABORT = 3;
  localparam int ST_DETECT = 4;
  localparam int ST_CHANGE = 5;
  localparam int ST_TX_READY = 6;
  localparam int ST_UNDERFLOW = 7;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BIT_RATE_BPS = 1200;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
  localparam int RING_HZ = 25;
  localparam int RING_PHASES = 256;
  localparam int RING_STEP_CYCLES = CLK_HZ / (RING_HZ * RING_PHASES);
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
  localparam logic [3:0] ASYNC_LAST_BIT = 4'h9;

  // -----------------------------------------------------------------
  // levels in dB of loss: two dB per level step, tones below full scale
  // -----------------------------------------------------------------
  localparam logic [4:0] HIGH_TONE_LOSS_DB = 5'h03;
  localparam logic [4:0] LOW_TONE_LOSS_DB = 5'h05;

  // -----------------------------------------------------------------
  // ring waveform shaping
  // -----------------------------------------------------------------
  localparam logic [1:0] RING_SQUARE = 2'h0;
  localparam logic [1:0] RING_TRAPEZOID = 2'h1;
  localparam logic [1:0] RING_SINE = 2'h2;
  localparam logic [7:0] RING_MID = 8'h80;
  localparam logic [7:0] RING_TOP = 8'hff;
  localparam logic [7:0] RING_BOTTOM = 8'h00;
  localparam logic [6:0] RING_SWING = 7'h7f;
  // ramp of 43 of 64 quarter steps gives crest factor 1.35
  localparam logic [7:0] TRAP_SLOPE = 8'hbd;
  localparam logic [15:0][5:0] SINE_QUARTER = {6'h3f, 6'h3e, 6'h3d, 6'h3b, 6'h39, 6'h36, 6'h33, 6'h2f,
                                               6'h2a, 6'h26, 6'h20, 6'h1b, 6'h15, 6'h0f, 6'h09, 6'h03};

  // keytone code by {low group index, high group index}
  localparam logic [15:0][3:0] KEY_CODE_LUT = {4'h0, 4'hc, 4'ha, 4'hb, 4'hf, 4'h9, 4'h8, 4'h7,
                                               4'he, 4'h6, 4'h5, 4'h4, 4'hd, 4'h3, 4'h2, 4'h1};

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } ftu_tx_state_t;

  typedef struct packed {
    logic present;     // a tone pair is recognised
    logic [1:0] low;   // low group: 697, 770, 852, 941 Hz
    logic [1:0] high;  // high group: 1209, 1336, 1477, 1633 Hz
  } ftu_keytone_t;

  typedef struct packed {
    logic [4:0] single_loss;  // single tone and fsk loss in dB
    logic [4:0] high_loss;    // high group tone loss in dB
    logic [4:0] low_loss;     // low group tone loss in dB
  } ftu_levels_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] mode;
    logic [7:0] tones;
    logic [7:0] link;
    logic [7:0] codec;
  } ftu_ctrl_t;

endpackage : ftu_pkg

/* ftu_ring_gen.sv */
// ring waveform generator: square, trapezoid and sine samples
`timescale 1ns/1ps
module ftu_ring_gen
  import ftu_pkg::*;
#(
  parameter int STEP_CYCLES = RING_STEP_CYCLES
) (
  input wire logic clk_i,               // system clock
  input wire logic rst_i,               // synchronous reset
  input wire logic active_i,            // ring selected for output
  input wire logic [1:0] wave_i,        // waveform select
  output logic [7:0] sample_o           // ring sample, 0 is low supply
);

  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [7:0] phase_reg;
  logic [7:0] phase_next;
  logic [7:0] sample_reg;
  logic [7:0] sample_next;
  logic [5:0] quarter;
  logic [13:0] ramp_prod;
  logic [6:0] trap_amp;
  logic [6:0] sine_amp;
  logic [6:0] amp;
  logic negative;

  // phase divider
  assign div_next = (div_reg == 16'(STEP_CYCLES - 1)) ? 16'h0000 : div_reg + 16'h0001;
  assign phase_next = (div_reg == 16'(STEP_CYCLES - 1)) ? phase_reg + 8'h01 : phase_reg;

  // quarter wave position, mirrored in the falling quarters
  assign quarter = phase_reg[6] ? ~phase_reg[5:0] : phase_reg[5:0];
  assign negative = phase_reg[7];
  assign ramp_prod = {8'h00, quarter} * {6'h00, TRAP_SLOPE};
  assign trap_amp = (ramp_prod[13:6] > {1'b0, RING_SWING}) ? RING_SWING : ramp_prod[12:6];
  assign sine_amp = {1'b0, SINE_QUARTER[quarter[5:2]]}; // half swing sine
  assign amp = (wave_i == RING_SINE) ? sine_amp : trap_amp;

  // sample selection; anything not selected sits at the low rail
  assign sample_next = !active_i ? RING_BOTTOM :
                       (wave_i == RING_SQUARE) ? (negative ? RING_BOTTOM : RING_TOP) :
                       (wave_i == RING_TRAPEZOID || wave_i == RING_SINE) ?
                       (negative ? RING_MID - {1'b0, amp} : RING_MID + {1'b0, amp}) :
                       RING_BOTTOM;

  // divider and phase registers
  always_ff @(posedge clk_i) begin
    if (rst_i || !active_i) begin
      div_reg <= 16'h0000;
      phase_reg <= 8'h00;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
    end
  end

  // output sample register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= RING_BOTTOM;
    end else begin
      sample_reg <= sample_next;
    end
  end

  assign sample_o = sample_reg;

endmodule : ftu_ring_gen

/* ftu_top.sv */
// fsk transmit serialiser, level and ring control, keytone status and wishbone registers
`timescale 1ns/1ps
module ftu_top
  import ftu_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES,
  parameter int RING_STEP_P = RING_STEP_CYCLES
) (
  input wire logic clk_i,                 // system clock, 40 MHz
  input wire logic rst_i,                 // synchronous reset, active high
  input wire logic cyc_i,                 // wishbone cycle
  input wire logic stb_i,                 // wishbone strobe
  input wire logic we_i,                  // wishbone write enable
  input wire logic [7:0] adr_i,           // wishbone byte address
  input wire logic [3:0] sel_i,           // wishbone byte selects
  input wire logic [31:0] dat_i,          // wishbone write data
  output logic [31:0] dat_o,              // wishbone read data
  output logic ack_o,                     // wishbone acknowledge
  input wire ftu_keytone_t keytone_i,     // tone decoder result
  input wire logic ring_active_i,         // ring routed to its pin
  input wire logic rx_abort_i,            // link receive abort pulse
  input wire logic tx_abort_i,            // link transmit abort pulse
  output logic fsk_bit_o,                 // serial bit to fsk encoder
  output logic fsk_busy_o,                // serialiser sending a character
  output ftu_levels_t levels_o,           // output level losses
  output logic [7:0] ring_sample_o,       // ring waveform sample
  output ftu_ctrl_t ctrl_o,               // stored configuration
  output logic irq_request_n_o            // interrupt request, active low
);

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic mapped;
  logic soft_reset;
  logic clr_all;
  logic wr_setup;
  logic wr_mode;
  logic wr_tx;
  logic wr_tones;
  logic wr_link;
  logic wr_mask;
  logic wr_codec;
  logic rd_status;

  // a request is taken on the first edge of the strobe, ack follows
  assign req = cyc_i && stb_i && !ack_reg;
  assign idx = adr_i[5:2];
  assign mapped = (adr_i[7:6] == 2'b00) && (adr_i[1:0] == 2'b00);
  assign wr = req && we_i && sel_i[0] && mapped;
  assign rd = req && !we_i && mapped;
  assign soft_reset = req && mapped && (idx == IDX_RESET);
  assign clr_all = rst_i || soft_reset;
  assign wr_setup = wr && (idx == IDX_SETUP);
  assign wr_mode = wr && (idx == IDX_MODE);
  assign wr_tx = wr && (idx == IDX_TX_DATA);
  assign wr_tones = wr && (idx == IDX_TX_TONES);
  assign wr_link = wr && (idx == IDX_LINK_CTRL);
  assign wr_mask = wr && (idx == IDX_INT_MASK);
  assign wr_codec = wr && (idx == IDX_CODEC_CTRL);
  assign rd_status = rd && (idx == IDX_STATUS);

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  logic [7:0] setup_reg;
  logic [7:0] mode_reg;
  logic [7:0] tones_reg;
  logic [7:0] link_reg;
  logic [7:0] mask_reg;
  logic [7:0] codec_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic hold_full_next;
  logic tx_en;
  logic async_mode;
  logic dec_en;

  assign tx_en = setup_reg[SETUP_TX_EN_BIT];
  assign async_mode = setup_reg[SETUP_ASYNC_BIT];
  assign dec_en = setup_reg[SETUP_DEC_EN_BIT];

  // software written registers, all cleared by the reset register
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      setup_reg <= REG_RESET_VALUE;
      mode_reg <= REG_RESET_VALUE;
      tones_reg <= REG_RESET_VALUE;
      link_reg <= REG_RESET_VALUE;
      mask_reg <= REG_RESET_VALUE;
      codec_reg <= REG_RESET_VALUE;
      hold_reg <= REG_RESET_VALUE;
    end else begin
      if (wr_setup) setup_reg <= dat_i[7:0];
      if (wr_mode) mode_reg <= dat_i[7:0];
      if (wr_tones) tones_reg <= dat_i[7:0];
      if (wr_link) link_reg <= dat_i[7:0];
      if (wr_mask) mask_reg <= dat_i[7:0] & INT_MASK_WRITABLE;
      if (wr_codec) codec_reg <= dat_i[7:0];
      if (wr_tx) hold_reg <= dat_i[7:0];
    end
  end

  assign ctrl_o = '{setup: setup_reg, mode: mode_reg, tones: tones_reg, link: link_reg, codec: codec_reg};

  // -----------------------------------------------------------------
  // level control
  // -----------------------------------------------------------------
  logic [4:0] step_loss;
  logic [2:0] level_code;

  assign level_code = mode_reg[MODE_LEVEL_LSB +: 3];
  assign step_loss = {1'b0, level_code, 1'b0};
  assign levels_o = '{single_loss: step_loss,
                      high_loss: step_loss + HIGH_TONE_LOSS_DB,
                      low_loss: step_loss + LOW_TONE_LOSS_DB};

  // -----------------------------------------------------------------
  // ring generator
  // -----------------------------------------------------------------
  ftu_ring_gen #(
    .STEP_CYCLES(RING_STEP_P)
  ) u_ring (
    .clk_i(clk_i),
    .rst_i(clr_all),
    .active_i(ring_active_i),
    .wave_i(setup_reg[SETUP_RING_LSB +: 2]),
    .sample_o(ring_sample_o)
  );

  // -----------------------------------------------------------------
  // serialiser
  // -----------------------------------------------------------------
  ftu_tx_state_t state_reg;
  ftu_tx_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [3:0] bit_idx_reg;
  logic [3:0] bit_idx_next;
  logic [9:0] shift_reg;
  logic [9:0] shift_next;
  logic bit_out_reg;
  logic bit_end;
  logic char_end;
  logic load;
  logic resend;
  logic uflow_set;
  logic ready_set;
  logic [9:0] frame_hold;
  logic [3:0] last_bit;

  assign bit_end = (cnt_reg == 16'(BIT_CYCLES_P - 1));
  assign last_bit = async_mode ? ASYNC_LAST_BIT : SYNC_LAST_BIT;
  assign char_end = (state_reg == TX_SEND) && bit_end && (bit_idx_reg == last_bit);
  // async frame: space start, data lsb first, mark stop
  assign frame_hold = async_mode ? {1'b1, hold_reg, 1'b0} : {2'b11, hold_reg};
  // a fresh byte is taken from idle or at the end of a character
  assign load = tx_en && hold_full_reg && ((state_reg == TX_IDLE) || char_end);
  // in sync framing a missing byte means the held one goes again
  assign resend = tx_en && char_end && !hold_full_reg && !async_mode;
  assign uflow_set = tx_en && char_end && !hold_full_reg;
  assign ready_set = load || (tx_en && (state_reg == TX_IDLE) && !hold_full_reg);
  assign hold_full_next = wr_tx ? 1'b1 : (load ? 1'b0 : hold_full_reg);

  // next state of the serialiser
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_idx_next = bit_idx_reg;
    shift_next = shift_reg;
    case (state_reg)
      TX_IDLE: begin
        if (load) begin
          state_next = TX_SEND;
          cnt_next = 16'h0000;
          bit_idx_next = 4'h0;
          shift_next = frame_hold;
        end
      end
      TX_SEND: begin
        cnt_next = bit_end ? 16'h0000 : cnt_reg + 16'h0001;
        if (!tx_en) begin
          state_next = TX_IDLE;
        end else if (load || resend) begin
          bit_idx_next = 4'h0;
          shift_next = frame_hold;
        end else if (char_end) begin
          state_next = TX_IDLE;
        end else if (bit_end) begin
          bit_idx_next = bit_idx_reg + 4'h1;
          shift_next = {1'b1, shift_reg[9:1]};
        end
      end
      default: begin
        state_next = TX_IDLE;
      end
    endcase
  end

  // serialiser registers; idle line is mark
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      state_reg <= TX_IDLE;
      cnt_reg <= 16'h0000;
      bit_idx_reg <= 4'h0;
      shift_reg <= 10'h3ff;
      bit_out_reg <= 1'b1;
      hold_full_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_idx_reg <= bit_idx_next;
      shift_reg <= shift_next;
      bit_out_reg <= (state_next == TX_SEND) ? shift_next[0] : 1'b1;
      hold_full_reg <= hold_full_next;
    end
  end

  assign fsk_bit_o = bit_out_reg;
  assign fsk_busy_o = (state_reg == TX_SEND);

  // -----------------------------------------------------------------
  // keytone decoder status
  // -----------------------------------------------------------------
  logic present;
  logic present_reg;
  logic tone_change;
  logic [3:0] digit_reg;

  assign present = dec_en && keytone_i.present;
  assign tone_change = dec_en && (present != present_reg);

  // detect level and latched digit code
  always_ff @(posedge clk_i) begin
    if (clr_all || !dec_en) begin
      present_reg <= 1'b0;
      digit_reg <= 4'h0;
    end else begin
      present_reg <= present;
      if (present && !present_reg) digit_reg <= KEY_CODE_LUT[{keytone_i.low, keytone_i.high}];
    end
  end

  // -----------------------------------------------------------------
  // status flags: set wins over clear
  // -----------------------------------------------------------------
  logic [7:0] stat_reg;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  logic [7:0] status_view;

  assign stat_set = {uflow_set, ready_set, tone_change, 1'b0, tx_abort_i, rx_abort_i, 2'b00};
  // read of status clears 2, 3, 5; a data write clears 6, 7
  assign stat_clr = {wr_tx, wr_tx, rd_status || !dec_en, 1'b0, rd_status, rd_status, 2'b00};

  // one flag per sticky status bit
  genvar i;
  generate
    for (i = ST_RX_ABORT; i <= ST_UNDERFLOW; i++) begin : g_flag
      if (i == ST_DETECT) begin : g_level
        assign stat_reg[i] = present_reg;
      end else begin : g_sticky
        logic flag_reg;
        always_ff @(posedge clk_i) begin
          if (clr_all) begin
            flag_reg <= 1'b0;
          end else begin
            flag_reg <= (stat_set[i] && (i != ST_CHANGE || dec_en)) || (flag_reg && !stat_clr[i]);
          end
        end
        assign stat_reg[i] = flag_reg;
      end
    end
  endgenerate
  assign stat_reg[1:0] = 2'b00;
  assign status_view = stat_reg;

  // -----------------------------------------------------------------
  // interrupt request
  // -----------------------------------------------------------------
  logic irq_armed_reg;
  logic irq_n_reg;
  logic new_event;
  logic irq_armed_next;

  // a status read releases the line until a fresh event arrives
  assign new_event = (|stat_set) || (present && !present_reg);
  assign irq_armed_next = new_event ? 1'b1 : (rd_status ? 1'b0 : irq_armed_reg);

  // armed flag and output driver
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      irq_armed_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      irq_armed_reg <= irq_armed_next;
      irq_n_reg <= !(irq_armed_next && |(status_view & mask_reg));
    end
  end

  assign irq_request_n_o = irq_n_reg;

  // -----------------------------------------------------------------
  // read data and acknowledge
  // -----------------------------------------------------------------
  assign rdata_next = !mapped ? 32'h0000_0000 :
                      (idx == IDX_DEVICE_ID) ? {24'h00_0000, DEVICE_ID_VALUE} :
                      (idx == IDX_STATUS) ? {24'h00_0000, status_view} :
                      (idx == IDX_DIGIT) ? {28'h000_0000, digit_reg} :
                      32'h0000_0000;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req && !we_i) rdata_reg <= rdata_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

endmodule : ftu_top

/* ftu_asserts.sv */
// port checker for the fsk transmit, ring and keytone status block
`timescale 1ns/1ps
module ftu_asserts
  import ftu_pkg::*;
(
  input wire logic clk_i,                // system clock
  input wire logic rst_i,                // synchronous reset
  input wire logic cyc_i,                // bus cycle
  input wire logic stb_i,                // bus strobe
  input wire logic ack_o,                // bus acknowledge
  input wire logic [31:0] dat_o,         // read data
  input wire logic ring_active_i,        // ring routed
  input wire logic [7:0] ring_sample_o,  // ring sample
  input wire logic fsk_bit_o,            // serial bit
  input wire logic fsk_busy_o,           // character in progress
  input wire ftu_levels_t levels_o,      // level losses
  input wire ftu_ctrl_t ctrl_o           // stored configuration
);
  // all checks sample on the rising edge and rest during reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answers:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acknowledged");
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_read_upper_zero:
    assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read data not zero");
  a_level_step:
    assert property (levels_o.single_loss == {1'b0, ctrl_o.mode[4:2], 1'b0}) else $error("level loss wrong");
  a_tone_skew:
    assert property (levels_o.high_loss == levels_o.single_loss + 5'h03 &&
                     levels_o.low_loss == levels_o.high_loss + 5'h02) else $error("tone skew wrong");
  a_ring_rest_low:
    assert property (!ring_active_i ##1 !ring_active_i |-> ring_sample_o == 8'h00) else $error("ring not low");
  a_async_start:
    assert property ($rose(fsk_busy_o) && ctrl_o.setup[1] |-> ##[0:1] !fsk_bit_o) else $error("no start bit");
  a_idle_mark:
    assert property (!fsk_busy_o ##1 !fsk_busy_o |-> fsk_bit_o) else $error("idle line not mark");
endmodule : ftu_asserts

bind ftu_top ftu_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .ring_active_i(ring_active_i), .ring_sample_o(ring_sample_o), .fsk_bit_o(fsk_bit_o),
  .fsk_busy_o(fsk_busy_o), .levels_o(levels_o), .ctrl_o(ctrl_o));

/* ftu_fsk_sink.sv */
// fsk encoder side model: samples the serial stream mid-bit into frames
`timescale 1ns/1ps
module ftu_fsk_sink #(
  parameter int BIT_P = 8
) (
  input wire logic clk_i,         // system clock
  input wire logic busy_i,        // character in progress
  input wire logic bit_i,         // serial bit
  input wire logic [3:0] nbits_i, // bits per frame
  output logic [9:0] frame_o,     // last frame, last bit on top
  output int count_o              // frames seen
);
  logic [9:0] shift_reg = 10'h000;
  int phase_reg = 0;
  int got_reg = 0;
  initial count_o = 0;
  // phase restarts whenever the line goes idle so sampling lands mid-bit
  always @(posedge clk_i) begin
    if (!busy_i) begin
      phase_reg <= 0;
      got_reg <= 0;
    end else begin
      phase_reg <= (phase_reg == BIT_P - 1) ? 0 : phase_reg + 1;
      if (phase_reg == BIT_P / 2) begin
        shift_reg <= {bit_i, shift_reg[9:1]};
        got_reg <= (got_reg + 1 == int'(nbits_i)) ? 0 : got_reg + 1;
        if (got_reg + 1 == int'(nbits_i)) begin
          frame_o <= {bit_i, shift_reg[9:1]};
          count_o <= count_o + 1;
        end
      end
    end
  end
endmodule : ftu_fsk_sink

/* testbench.sv */
// self-checking bench for the fsk transmit, ring and keytone status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  import ftu_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ring_active_i = 0, rx_abort_i = 0, tx_abort_i = 0;
  logic [7:0] adr_i = 8'h00, q, ring_sample_o;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, fsk_bit_o, fsk_busy_o, irq_request_n_o;
  ftu_keytone_t keytone_i = '0;
  ftu_levels_t levels_o;
  ftu_ctrl_t ctrl_o;
  logic [3:0] nbits = 4'ha;
  logic [9:0] frame;
  logic [63:0] key_codes = 64'h0cabf987e654d321;
  int frames, n, k, errors = 0, comparisons = 0;

  ftu_top #(.BIT_CYCLES_P(8), .RING_STEP_P(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .keytone_i(keytone_i), .ring_active_i(ring_active_i), .rx_abort_i(rx_abort_i), .tx_abort_i(tx_abort_i),
    .fsk_bit_o(fsk_bit_o), .fsk_busy_o(fsk_busy_o), .levels_o(levels_o), .ring_sample_o(ring_sample_o),
    .ctrl_o(ctrl_o), .irq_request_n_o(irq_request_n_o));
  ftu_fsk_sink #(.BIT_P(8)) i_sink (.clk_i(clk_i), .busy_i(fsk_busy_o), .bit_i(fsk_bit_o), .nbits_i(nbits),
    .frame_o(frame), .count_o(frames));

  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;

  // one classic bus cycle, held until ack is seen
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) errors++;
    q = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, e, q)
  endtask : rd

  // waits for the sink to finish one more frame
  task next_frame;
    k = frames; n = 0;
    while (frames == k && n < 400) begin @(posedge clk_i); n++; end
    if (n >= 400) errors++;
  endtask : next_frame

  task print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, DEVICE_ID_VALUE, "id");
    rd(8'h1c, 8'h00, "unmapped");
    rx_abort_i <= 1'b1; tx_abort_i <= 1'b1; @(posedge clk_i);
    rx_abort_i <= 1'b0; tx_abort_i <= 1'b0; @(posedge clk_i);
    rd(8'h28, 8'h0c, "abort flag");
    rd(8'h28, 8'h00, "abort cleared");
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 8'h10, 8'(c << 2));
      `CHK("level", 5'(2 * c), levels_o.single_loss)
      `CHK("low tone", 5'(5 + 2 * c), levels_o.low_loss)
    end
    ring_active_i <= 1'b1; n = 0;
    while (ring_sample_o !== 8'hff && n < 2000) begin @(posedge clk_i); n++; end
    `CHK("square top", 8'hff, ring_sample_o)
    ring_active_i <= 1'b0; repeat (3) @(posedge clk_i);
    `CHK("ring rest", 8'h00, ring_sample_o)
    // trapezoid then sine: peak over one full ring period, and trapezoid crest factor
    for (int w = 1; w < 3; w++) begin
      xfer(1'b1, 8'h0c, 8'(w << 2));
      ring_active_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      k = 0;
      n = 0;
      repeat (512) begin
        @(posedge clk_i);
        n += (int'(ring_sample_o) - 128) ** 2;
        if (ring_sample_o > k) k = ring_sample_o;
      end
      `CHK("ring peak", (w == 1) ? 8'hff : 8'hbf, 8'(k))
      `CHK("crest", 1'b1, w == 2 || ((100 * 127 * 127 * 512 / n) inside {[176:190]}))
      ring_active_i <= 1'b0;
    end
    xfer(1'b1, 8'h24, 8'h20);
    xfer(1'b1, 8'h0c, 8'h20);
    for (int t = 0; t < 16; t++) begin
      keytone_i <= {1'b1, 4'(t)}; repeat (3) @(posedge clk_i);
      `CHK("irq", 1'b0, irq_request_n_o)
      rd(8'h28, 8'h30, "detect");
      rd(8'h2c, {4'h0, key_codes[4*t +: 4]}, "digit");
      `CHK("irq released", 1'b1, irq_request_n_o)
      keytone_i <= '0; repeat (3) @(posedge clk_i);
      rd(8'h28, 8'h20, "loss");
    end
    keytone_i <= {1'b1, 4'h5}; repeat (3) @(posedge clk_i);
    xfer(1'b1, 8'h0c, 8'h00);
    @(posedge clk_i);
    `CHK("off irq", 1'b1, irq_request_n_o)
    rd(8'h28, 8'h00, "off status");
    rd(8'h2c, 8'h00, "off digit");
    keytone_i <= '0;
    xfer(1'b1, 8'h0c, 8'h42);
    xfer(1'b1, 8'h14, 8'ha5);
    rd(8'h28, 8'h40, "ready");
    xfer(1'b1, 8'h14, 8'h3c);
    next_frame();
    `CHK("async a", {1'b1, 8'ha5, 1'b0}, frame)
    next_frame();
    `CHK("async b", {1'b1, 8'h3c, 1'b0}, frame)
    repeat (20) @(posedge clk_i);
    `CHK("mark", 1'b1, fsk_bit_o)
    rd(8'h28, 8'hc0, "underflow");
    xfer(1'b1, 8'h14, 8'h00);
    rd(8'h28, 8'h40, "underflow cleared");
    xfer(1'b1, 8'h04, 8'h00);
    nbits <= 4'h8;
    xfer(1'b1, 8'h0c, 8'h40);
    xfer(1'b1, 8'h14, 8'h96);
    next_frame();
    `CHK("sync", 8'h96, frame[9:2])
    next_frame();
    `CHK("resend", 8'h96, frame[9:2])
    xfer(1'b0, 8'h28, 8'h00);
    `CHK("sync underflow", 1'b1, q[7])
    print_verdict();
  end
endmodule : testbench
